//--- rtl/ssp_params.svh
/*
 Constants of the shared serial port: register offsets, field
 positions, reset values, mode codes and divider counts.
 Assumes a byte-addressed Avalon-MM slave with one word per register.
*/
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_ADDR_W    5
`define SSP_A_MODE    5'h00
`define SSP_A_LINK    5'h04
`define SSP_A_DATA    5'h08
`define SSP_A_STAT    5'h0C
`define SSP_A_MASK    5'h10
`define SSP_MODE_POR  8'hE0
`define SSP_LINK_POR  8'h00
`define SSP_DATA_POR  8'h00
`define SSP_MC_OPM    7:5
`define SSP_MC_UART   4
`define SSP_MC_EN     1
`define SSP_MC_INC    0
`define SSP_LC_POL    5
`define SSP_LC_EDGE   4
`define SSP_LC_ORDER  3
`define SSP_LC_SEL    2
`define SSP_LC_COLL   1
`define SSP_LC_DONE   0
`define SSP_OPM_DIV4  3'h0
`define SSP_OPM_DIV16 3'h1
`define SSP_OPM_DIV64 3'h2
`define SSP_OPM_SUB   3'h3
`define SSP_OPM_TIMER 3'h4
`define SSP_OPM_SLAVE 3'h5
`define SSP_HALF_DIV4  2
`define SSP_HALF_DIV16 8
`define SSP_HALF_DIV64 32
`define SSP_IRQ_W     3
`define SSP_IRQ_DONE  0
`define SSP_IRQ_COLL  1
`define SSP_IRQ_INC   2
`define SSP_BITS      4'h8
`define SSP_LAST_TOG  4'hF
`define SSP_TOP_BIT   3'h7
`endif

//--- rtl/ssp_pkg.sv
/*
 Types of the shared serial port: state codes, pin carrier and the
 register state of the top module.
 Assumes ssp_params.svh is on the include path.
*/
`include "ssp_params.svh"
package ssp_pkg;
	typedef enum logic [1:0] {
		SSP_IDLE = 2'h1,
		SSP_BUSY = 2'h2
	} ssp_fsm_t;

	// serial pins, each with its output enable
	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic sdo;
		logic sdo_oe;
		logic ss_n;
		logic ss_n_oe;
	} ssp_pins_t;

	typedef struct packed {
		logic [7:0]            mode;
		logic [7:0]            link;
		logic [7:0]            data;
		logic [7:0]            rx;
		logic [`SSP_IRQ_W-1:0] stat;
		logic [`SSP_IRQ_W-1:0] mask;
		ssp_fsm_t              fsm;
		logic [2:0]            ob;
		logic [3:0]            caps;
		logic [3:0]            tog;
		logic                  pend;
		logic                  fin;
		logic [2:0]            sck_s;
		logic [2:0]            ss_s;
		logic [2:0]            sub_s;
		logic [1:0]            sdi_s;
		ssp_pins_t             pins;
		logic [3:0]            pull;
		logic                  irq;
		logic [7:0]            rdata;
		logic                  wait_req;
	} ssp_state_t;
endpackage

//--- rtl/ssp_clkdiv.sv
/*
 Serial clock tick generator for master mode: one-cycle pulse per
 half period of the serial clock.
 Assumes sub_edge_i and timer_tick_i are pulses on clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_clkdiv #(
	parameter int CNT_W = 5
) (
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic       run_i,
	input  wire logic [2:0] sel_i,
	input  wire logic       sub_edge_i,
	input  wire logic       timer_tick_i,
	output logic            tick_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} ssp_div_t;

	ssp_div_t         s;
	ssp_div_t         next_s;
	logic [CNT_W-1:0] lim;

	// counter must hold the largest half period
	if (CNT_W < $clog2(`SSP_HALF_DIV64)) begin : g_chk
		$error("ssp_clkdiv: CNT_W too small");
	end

	// stopped counter restarts so the first half period is whole
	always_comb begin
		next_s = s;
		next_s.tick = 1'h0;
		lim = CNT_W'(`SSP_HALF_DIV4 - 1);
		if (!run_i) begin
			next_s.cnt = '0;
		end else begin
			case (sel_i)
				`SSP_OPM_DIV16: lim = CNT_W'(`SSP_HALF_DIV16 - 1);
				`SSP_OPM_DIV64: lim = CNT_W'(`SSP_HALF_DIV64 - 1);
				default:        lim = CNT_W'(`SSP_HALF_DIV4 - 1);
			endcase
			if (sel_i == `SSP_OPM_SUB) begin
				next_s.tick = sub_edge_i;
			end else if (sel_i == `SSP_OPM_TIMER) begin
				next_s.tick = timer_tick_i; // sck is match rate / 2
			end else if (s.cnt == lim) begin
				next_s.cnt  = '0;
				next_s.tick = 1'h1;
			end else begin
				next_s.cnt = s.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;
endmodule // ssp_clkdiv
`default_nettype wire

//--- rtl/ssp_top.sv
/*
 SPI function of the shared serial module: Avalon-MM register slave,
 master and slave byte shifter, interrupt status and mask.
 Assumes pins are tri-stated outside from the *_oe fields, pull-up
 settings arrive on clock_i, and the timer tick is a clock_i pulse.
*/
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_top #(
	parameter int CNT_W = 5
) (
	input  wire logic                   clock_i,
	input  wire logic                   reset_i,
	input  wire logic [`SSP_ADDR_W-1:0] avs_address_i,
	input  wire logic                   avs_read_i,
	input  wire logic                   avs_write_i,
	input  wire logic [31:0]            avs_writedata_i,
	input  wire logic [3:0]             avs_byteenable_i,
	output logic      [31:0]            avs_readdata_o,
	output logic                        avs_waitrequest_o,
	input  wire logic                   sdi_i,
	input  wire logic                   sck_i,
	input  wire logic                   ss_n_i,
	input  wire logic                   sub_clk_i,
	input  wire logic                   timer_tick_i,
	input  wire logic [3:0]             pull_cfg_i,
	output ssp_pkg::ssp_pins_t          pins_o,
	output logic      [3:0]             pullup_o,
	output logic                        irq_o
);
	ssp_pkg::ssp_state_t s;
	ssp_pkg::ssp_state_t next_s;

	logic       spi_sel;
	logic       spi_on;
	logic       master;
	logic       slave;
	logic       busy;
	logic       sel_en;
	logic       sel_ok;
	logic       idle_lvl;
	logic       cap_rise;
	logic       tick;
	logic       sub_edge;
	logic [7:0] wd;
	logic       wr_take;
	logic [7:0] rx_nxt;
	logic       e_rise;
	logic       e_fall;
	logic       cap;
	logic       take;
	logic       launch;
	logic       go;
	logic       act;
	logic       leave;
	logic       done;
	logic       coll;
	logic       inc;
	logic       sdi;

	// function decode from the uart bit and mode field
	assign spi_sel = !s.mode[`SSP_MC_UART] &&
		(s.mode[`SSP_MC_OPM] <= `SSP_OPM_SLAVE);
	assign spi_on  = spi_sel && s.mode[`SSP_MC_EN];
	assign master  = spi_on && (s.mode[`SSP_MC_OPM] != `SSP_OPM_SLAVE);
	assign slave   = spi_on && (s.mode[`SSP_MC_OPM] == `SSP_OPM_SLAVE);
	assign busy    = (s.fsm == ssp_pkg::SSP_BUSY);
	assign sel_en  = s.link[`SSP_LC_SEL];
	assign sel_ok  = !sel_en || !s.ss_s[1];
	// idle high at polarity 0; polarity 1 flips the edge choice
	assign idle_lvl = !s.link[`SSP_LC_POL];
	assign cap_rise = (s.link[`SSP_LC_POL] == s.link[`SSP_LC_EDGE]);
	assign sub_edge = s.sub_s[1] ^ s.sub_s[2];
	assign sdi      = s.sdi_s[1];
	assign wd       = avs_writedata_i[7:0];
	// write lands only at the edge where waitrequest is low
	assign wr_take  = avs_write_i && !s.wait_req && avs_byteenable_i[0];

	// master clock source per mode code
	ssp_clkdiv #(
		.CNT_W(CNT_W)
	) u_div (
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.run_i        (master && busy),
		.sel_i        (s.mode[`SSP_MC_OPM]),
		.sub_edge_i   (sub_edge),
		.timer_tick_i (timer_tick_i),
		.tick_o       (tick)
	);

	// all next-state logic of the port
	always_comb begin
		next_s = s;
		rx_nxt = s.rx;
		e_rise = 1'h0;
		e_fall = 1'h0;
		cap    = 1'h0;
		take   = 1'h0;
		launch = 1'h0;
		go     = 1'h0;
		act    = 1'h0;
		leave  = 1'h0;
		done   = 1'h0;
		coll   = 1'h0;
		inc    = 1'h0;
		// pins from outside cross two flops before use
		next_s.sck_s = {s.sck_s[1:0], sck_i};
		next_s.ss_s  = {s.ss_s[1:0], ss_n_i};
		next_s.sub_s = {s.sub_s[1:0], sub_clk_i};
		next_s.sdi_s = {s.sdi_s[0], sdi_i};

		// one wait cycle per access, read data ready with the answer
		next_s.wait_req = 1'h1;
		if ((avs_read_i || avs_write_i) && s.wait_req) begin
			next_s.wait_req = 1'h0;
			case (avs_address_i)
				`SSP_A_MODE: next_s.rdata = s.mode;
				`SSP_A_LINK: next_s.rdata = spi_sel ? s.link : 8'h00;
				`SSP_A_DATA: next_s.rdata = spi_sel ? s.data : 8'h00;
				`SSP_A_STAT: next_s.rdata = {5'h00, s.stat};
				`SSP_A_MASK: next_s.rdata = {5'h00, s.mask};
				default:     next_s.rdata = 8'h00;
			endcase
		end

		// idle engine keeps its counters cleared
		if (!busy) begin
			next_s.caps = 4'h0;
			next_s.tog  = 4'h0;
			next_s.ob   = 3'h0;
			next_s.pend = 1'h0;
			next_s.fin  = 1'h0;
		end

		// register writes; flags only clear here, events set later
		if (wr_take) begin
			case (avs_address_i)
				`SSP_A_MODE: begin
					next_s.mode = wd;
					next_s.mode[`SSP_MC_INC] = s.mode[`SSP_MC_INC] &
						wd[`SSP_MC_INC];
				end
				`SSP_A_LINK: if (spi_sel) begin
					next_s.link = wd;
					next_s.link[`SSP_LC_DONE] = s.link[`SSP_LC_DONE] &
						wd[`SSP_LC_DONE];
					next_s.link[`SSP_LC_COLL] = s.link[`SSP_LC_COLL] &
						wd[`SSP_LC_COLL];
				end
				`SSP_A_DATA: if (spi_sel) begin
					if (busy) begin
						coll = 1'h1; // byte dropped
					end else begin
						next_s.data = wd;
						if (master) begin
							// only the master side starts a byte
							next_s.fsm = ssp_pkg::SSP_BUSY;
							next_s.rx  = 8'h00;
						end
					end
				end
				`SSP_A_STAT: next_s.stat = s.stat & ~wd[`SSP_IRQ_W-1:0];
				`SSP_A_MASK: next_s.mask = wd[`SSP_IRQ_W-1:0];
				default: ;
			endcase
		end

		// edge source: own divider as master, synced pin as slave
		if (master) begin
			// after sixteen toggles one quiet tick ends the byte; at edge select 0 it also takes the last bit
			if (busy && tick && !s.fin) begin
				next_s.pins.sck = !s.pins.sck;
				e_rise = !s.pins.sck;
				e_fall = s.pins.sck;
			end
			act = busy && !s.fin;
		end else if (slave) begin
			e_rise = s.sck_s[1] && !s.sck_s[2];
			e_fall = !s.sck_s[1] && s.sck_s[2];
			leave = idle_lvl ? e_fall : e_rise;
			go = !busy && sel_ok && leave;
			act = (busy && sel_ok) || go;
		end
		if (go) begin
			next_s.fsm = ssp_pkg::SSP_BUSY;
			next_s.rx  = 8'h00;
		end

		// capture on the chosen edge, launch on the other
		if (act) begin
			cap    = cap_rise ? e_rise : e_fall;
			launch = (e_rise || e_fall) && !cap;
		end
		// master sdi lags by its synchroniser: take it one tick late
		take = slave ? cap : (master && busy && tick && s.pend);
		if (take) begin
			next_s.pend = 1'h0;
		end
		if (cap && master) begin
			next_s.pend = 1'h1;
		end
		if (take) begin
			// one bit in per capture; the out bit moves on the launch edge
			rx_nxt = s.link[`SSP_LC_ORDER] ? {next_s.rx[6:0], sdi} :
				{sdi, next_s.rx[7:1]};
			next_s.rx   = rx_nxt;
			next_s.caps = next_s.caps + 4'h1;
		end
		// no shift before the first capture, so bit 0 is not skipped
		if (launch && (next_s.caps != 4'h0)) begin
			next_s.ob = next_s.ob + 3'h1;
		end
		if (master && busy && tick) begin
			next_s.tog = next_s.tog + 4'h1;
			if (s.fin) begin
				done = 1'h1;
				next_s.fin = 1'h0;
			end else if (s.tog == `SSP_LAST_TOG) begin
				next_s.fin = 1'h1; // 16 edges, 8 cycles
			end
		end
		if (slave && cap) begin
			done = (next_s.caps == `SSP_BITS);
		end
		if (done) begin
			next_s.data = next_s.rx;
			next_s.fsm  = ssp_pkg::SSP_IDLE;
		end

		// slave deselected mid-byte: abort and flag it
		if (slave && busy && sel_en && s.ss_s[1] && !s.ss_s[2] && !done) begin
			inc = 1'h1;
			next_s.fsm = ssp_pkg::SSP_IDLE;
		end
		if (!spi_on) begin
			next_s.fsm = ssp_pkg::SSP_IDLE;
		end

		// hardware sets win over a clear in the same cycle
		if (done || inc) begin
			next_s.link[`SSP_LC_DONE]  = 1'h1;
			next_s.stat[`SSP_IRQ_DONE] = 1'h1;
		end
		if (inc) begin
			next_s.mode[`SSP_MC_INC]  = 1'h1;
			next_s.stat[`SSP_IRQ_INC] = 1'h1;
		end
		if (coll) begin
			next_s.link[`SSP_LC_COLL]  = 1'h1;
			next_s.stat[`SSP_IRQ_COLL] = 1'h1;
		end

		// pin drive follows mode, enable and select enable
		if (!master || (next_s.fsm == ssp_pkg::SSP_IDLE)) begin
			next_s.pins.sck = idle_lvl;
		end
		next_s.pins.sck_oe = master;
		next_s.pins.sdo = s.link[`SSP_LC_ORDER] ?
			next_s.data[`SSP_TOP_BIT - next_s.ob] :
			next_s.data[next_s.ob];
		next_s.pins.sdo_oe = master || (slave && sel_ok);
		// a single select line; extra slaves need general pins
		next_s.pins.ss_n    = (next_s.fsm != ssp_pkg::SSP_BUSY);
		next_s.pins.ss_n_oe = master && sel_en;
		// pull-ups only on pins that are inputs of the live port
		next_s.pull = pull_cfg_i &
			{1'h0, slave && sel_en, slave, spi_on};
		next_s.irq = |(next_s.stat & next_s.mask);
	end

	// single synchronous register of all state
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s <= '{
				mode:     `SSP_MODE_POR,
				link:     `SSP_LINK_POR,
				data:     `SSP_DATA_POR,
				fsm:      ssp_pkg::SSP_IDLE,
				pins:     '{sck: 1'h1, ss_n: 1'h1, default: 1'h0},
				wait_req: 1'h1,
				default:  '0
			};
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata_o    = {24'h000000, s.rdata};
	assign avs_waitrequest_o = s.wait_req;
	assign pins_o            = s.pins;
	assign pullup_o          = s.pull;
	assign irq_o             = s.irq;

	// checks on the shifter, flags and pins
	default clocking ast_cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	sequence ast_xfer_end;
		busy ##1 !busy && !s.mode[`SSP_MC_INC] && $past(spi_on);
	endsequence

	sequence ast_data_wr_busy;
		wr_take && spi_sel && busy && (avs_address_i == `SSP_A_DATA);
	endsequence

	AST_DONE_FLAG: assert property (
		ast_xfer_end |-> s.link[`SSP_LC_DONE] && s.stat[`SSP_IRQ_DONE])
		else $error("done flag not set at end of byte");

	AST_WRITE_COLLIDE: assert property (
		ast_data_wr_busy |=> s.link[`SSP_LC_COLL] && s.stat[`SSP_IRQ_COLL])
		else $error("collision flag not set");

	AST_EIGHT_BITS: assert property (
		($fell(busy) && master && $past(master)) |-> s.caps == `SSP_BITS)
		else $error("master byte not eight bits");

	AST_IDLE_LEVEL: assert property (
		(master && !busy) |=> s.pins.sck == !$past(s.link[`SSP_LC_POL]))
		else $error("idle clock level wrong");

	AST_SS_FLOAT: assert property (
		!sel_en |=> !s.pins.ss_n_oe)
		else $error("select pin driven while disabled");

	AST_SLAVE_NO_CLOCK: assert property (
		(slave || !spi_on) |=> !s.pins.sck_oe && !$rose(busy && master))
		else $error("clock driven outside master mode");

	AST_LOCKED_READ: assert property (
		(avs_read_i && s.wait_req && !spi_sel &&
		(avs_address_i == `SSP_A_LINK)) |=> !s.wait_req && s.rdata == 8'h00)
		else $error("link control readable outside spi");

	AST_CAPTURE_STEP: assert property (
		(busy && take) |=> s.caps == $past(s.caps) + 4'h1)
		else $error("capture did not advance bit count");

	AST_FIRST_BIT: assert property (
		($rose(busy) && master) |-> s.pins.sdo ==
		(s.link[`SSP_LC_ORDER] ? s.data[7] : s.data[0]))
		else $error("first bit does not follow bit order");
endmodule // ssp_top
`default_nettype wire

//--- bench/ssp_spi_partner.sv
/*
 Behavioural SPI slave that faces the port in master mode.
 Assumes the bench tells it the clock polarity, capture edge and bit
 order, and feeds it a select already merged from pin and GPIO.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_partner (
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic       sck_i,
	input  wire logic       sdo_i,
	input  wire logic       sel_n_i,
	input  wire logic       pol_i,
	input  wire logic       edge_i,
	input  wire logic       msb_i,
	input  wire logic       slow_i,
	input  wire logic [7:0] tx_i,
	output logic            sdi_o,
	output logic [7:0]      rx_o,
	output logic [3:0]      count_o
);
	logic       sck_q;
	logic       sel_q;
	logic       late;
	logic       shifted;
	logic [2:0] idx;
	// capture on rise when polarity equals edge select
	wire logic  moved = (sck_i != sck_q);
	wire logic  cap   = moved && (sck_i == (pol_i == edge_i));
	wire logic  nxt   = msb_i ? tx_i[3'h6 - idx] : tx_i[idx + 3'h1];

	// no clock output at all: a slave never drives the clock
	always_ff @(posedge clock_i) begin
		sck_q <= sck_i;
		sel_q <= sel_n_i;
		if (reset_i) begin
			sdi_o <= 1'b0;
			late <= 1'b0;
			shifted <= 1'b0;
		end else if (sel_n_i) begin
			sdi_o <= ~sdi_o; // released line never holds its value
			late <= 1'b0;
			shifted <= 1'b0;
		end else if (sel_q) begin
			sdi_o <= msb_i ? tx_i[7] : tx_i[0];
			idx <= 3'h0;
			rx_o <= 8'h00;
			count_o <= 4'h0;
		end else begin
			// every captured bit pairs with one sent bit
			if (cap) begin
				rx_o <= msb_i ? {rx_o[6:0], sdo_i} : {sdo_i, rx_o[7:1]};
				count_o <= count_o + 4'h1;
				shifted <= 1'b1;
			end
			// a slow slave answers one cycle after the launch edge
			if ((moved && !cap && shifted && !slow_i) || late) begin
				sdi_o <= nxt;
				idx <= idx + 3'h1;
			end
			late <= moved && !cap && shifted && slow_i;
		end
	end
endmodule // ssp_spi_partner
`default_nettype wire

//--- bench/ssp_top_test.sv
/*
 Self-checking bench of the shared serial port: registers, master
 transfers on every clock source, slave transfers, interrupt.
 Assumes ssp_params.svh on the include path and the partner model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_top_test;
	logic               clock_i;
	logic               reset_i;
	logic [4:0]         adr;
	logic               rd;
	logic               wr;
	logic [31:0]        wdat;
	logic [3:0]         be;
	logic [31:0]        rdat;
	logic               wreq;
	logic               sck_m;
	logic               ss_m;
	logic               sdi_m;
	logic               sub_clk;
	logic               ttick;
	logic               noise;
	logic               gpio_n;
	logic               slave;
	logic               slow;
	logic [3:0]         pcfg;
	logic [3:0]         pu;
	logic               irq;
	logic               p_sdi;
	logic [7:0]         p_rx;
	logic [3:0]         p_cnt;
	logic [7:0]         p_tx;
	logic [2:0]         lcfg;
	logic [7:0]         q;
	logic [31:0]        seed;
	int                 failures;
	int                 num_checks;
	int                 cyc;
	ssp_pkg::ssp_pins_t pins;
	// deselected lines wander so stale data cannot pass
	wire logic sdi_w = slave ? (ss_m ? noise : sdi_m) : p_sdi;
	wire logic sel_n = pins.ss_n_oe ? pins.ss_n : gpio_n;

	ssp_top #(.CNT_W(5)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .sdi_i(sdi_w),
		.sck_i(sck_m), .ss_n_i(ss_m), .sub_clk_i(sub_clk),
		.timer_tick_i(ttick), .pull_cfg_i(pcfg), .pins_o(pins),
		.pullup_o(pu), .irq_o(irq));
	ssp_spi_partner i_partner (.clock_i(clock_i), .reset_i(reset_i),
		.sck_i(pins.sck), .sdo_i(pins.sdo), .sel_n_i(sel_n),
		.pol_i(lcfg[2]), .edge_i(lcfg[1]), .msb_i(lcfg[0]),
		.slow_i(slow), .tx_i(p_tx), .sdi_o(p_sdi), .rx_o(p_rx),
		.count_o(p_cnt));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// sub clock, timer pulses, noise and the hang limit
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		ttick <= (cyc % 3 == 0);
		noise <= ~noise;
		if (cyc % 5 == 0) sub_clk <= ~sub_clk;
		if (cyc == 40000) begin
			failures++;
			summarize();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge clock_i); while (wreq !== 1'b0);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic wait_done();
		q = 8'h00;
		for (int n = 0; n < 400 && q[0] !== 1'b1; n++) begin
			bus(1'b0, `SSP_A_LINK, 8'h00);
		end
	endtask

	task automatic run_master(input logic [2:0] code,
		input logic [2:0] cfg, input logic sel, input logic coll);
		logic [7:0] d;
		seed = xs(seed);
		d = seed[7:0];
		p_tx <= seed[15:8];
		lcfg <= cfg;
		slow <= (code == `SSP_OPM_DIV16) || (code == `SSP_OPM_DIV64);
		bus(1'b1, `SSP_A_MODE, {code, 5'h02});
		bus(1'b1, `SSP_A_LINK, {2'b00, cfg, sel, 2'b00});
		repeat (2) @(posedge clock_i);
		chk("idle sck", {7'h0, ~cfg[2]}, {7'h0, pins.sck});
		gpio_n <= 1'b0;
		bus(1'b1, `SSP_A_DATA, d);
		if (coll) bus(1'b1, `SSP_A_DATA, ~d);
		repeat (2) @(posedge clock_i);
		chk("select oe", {7'h0, sel}, {7'h0, pins.ss_n_oe});
		if (sel) chk("select low", 8'h00, {7'h0, pins.ss_n});
		wait_done();
		gpio_n <= 1'b1;
		chk("link flags", {6'h0, coll, 1'b1}, q & 8'h03);
		chk("slave saw", d, p_rx);
		chk("capture edges", 8'h08, {4'h0, p_cnt});
		bus(1'b0, `SSP_A_DATA, 8'h00);
		chk("rx byte", p_tx, q);
		bus(1'b1, `SSP_A_LINK, {2'b00, cfg, sel, 2'b00});
		$display("master code %0d done", code);
	endtask

	// bench plays master: sdi launched on falls, sdo read before rises
	task automatic run_slave(input int nb);
		logic [7:0] d;
		logic [7:0] m;
		logic [7:0] got;
		seed = xs(seed);
		d = seed[7:0];
		m = seed[15:8];
		got = 8'h00;
		slave <= 1'b1;
		bus(1'b1, `SSP_A_MODE, {`SSP_OPM_SLAVE, 5'h02});
		bus(1'b1, `SSP_A_LINK, 8'h0C);
		bus(1'b1, `SSP_A_DATA, d);
		ss_m <= 1'b0;
		sdi_m <= m[7];
		for (int b = 0; b < nb; b++) begin
			repeat (8) @(posedge clock_i);
			sck_m <= 1'b0;
			if (b > 0) sdi_m <= m[7 - b];
			repeat (8) @(posedge clock_i);
			got = {got[6:0], pins.sdo};
			sck_m <= 1'b1;
		end
		chk("slave sck oe", 8'h00, {7'h0, pins.sck_oe});
		repeat (8) @(posedge clock_i);
		ss_m <= 1'b1;
		wait_done();
		if (nb == 8) begin
			chk("slave sent", d, got);
			bus(1'b0, `SSP_A_DATA, 8'h00);
			chk("slave rx", m, q);
		end else begin
			bus(1'b0, `SSP_A_MODE, 8'h00);
			chk("incomplete", 8'h01, q & 8'h01);
		end
		$display("slave bits %0d done", nb);
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		{rd, wr, adr, wdat, slave, slow, sub_clk, ttick, noise} = '0;
		{sck_m, ss_m, sdi_m, gpio_n, be, pcfg} = {4'hF, 4'hF, 4'hF};
		{p_tx, lcfg, cyc, failures, num_checks} = '0;
		seed = 32'h53C7;
		reset_i = 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		bus(1'b0, `SSP_A_MODE, 8'h00);
		chk("mode reset", `SSP_MODE_POR, q);
		bus(1'b1, `SSP_A_LINK, 8'hC4);
		bus(1'b0, `SSP_A_LINK, 8'h00);
		chk("link hidden", 8'h00, q);
		bus(1'b0, 5'h14, 8'h00);
		chk("unmapped", 8'h00, q);
		bus(1'b1, `SSP_A_MODE, 8'h12);
		bus(1'b1, `SSP_A_DATA, 8'h5A);
		bus(1'b0, `SSP_A_DATA, 8'h00);
		chk("uart hides data", 8'h00, q);
		bus(1'b1, `SSP_A_MODE, 8'h00);
		repeat (3) @(posedge clock_i);
		chk("pullup off", 8'h00, {4'h0, pu});
		bus(1'b1, `SSP_A_MODE, 8'h02);
		repeat (3) @(posedge clock_i);
		chk("pullup sdi only", 8'h01, {4'h0, pu & 4'h3});
		chk("master sck oe", 8'h01, {7'h0, pins.sck_oe});
		$display("registers done");
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			run_master(i[2:0], {i[1:0], seed[0]}, i[0] ^ i[1], i == 1);
		end
		bus(1'b0, `SSP_A_STAT, 8'h00);
		chk("status", 8'h03, q);
		chk("irq masked", 8'h00, {7'h0, irq});
		bus(1'b1, `SSP_A_MASK, 8'h01);
		@(posedge clock_i);
		chk("irq raised", 8'h01, {7'h0, irq});
		bus(1'b1, `SSP_A_STAT, 8'h01);
		@(posedge clock_i);
		chk("irq cleared", 8'h00, {7'h0, irq});
		bus(1'b1, `SSP_A_STAT, 8'h02);
		$display("interrupt done");
		run_slave(8);
		run_slave(3);
		summarize();
	end
endmodule // ssp_top_test
`default_nettype wire
